// ### rtl/ctd_pkg.sv
// package for the control-transfer and operand decoder
// assumes nothing beyond a synthesizable SystemVerilog flow
package ctd_pkg;
   localparam logic [7:0] OP_RET_NEAR     = 8'hc3;
   localparam logic [7:0] OP_RET_NEAR_IMM = 8'hc2;
   localparam logic [7:0] OP_RET_FAR      = 8'hcb;
   localparam logic [7:0] OP_RET_FAR_IMM  = 8'hca;
   localparam logic [3:0] OP_JCC_HI       = 4'h7;
   localparam logic [7:0] OP_JUMP_CNT_Z   = 8'he3;
   localparam logic [7:0] OP_LOOP         = 8'he2;
   localparam logic [7:0] OP_LOOP_Z       = 8'he1;
   localparam logic [7:0] OP_LOOP_NZ      = 8'he0;
   localparam logic [7:0] OP_ENTER        = 8'hc8;
   localparam logic [7:0] OP_LEAVE        = 8'hc9;
   localparam logic [7:0] OP_INT_TYPE     = 8'hcd;
   localparam logic [7:0] OP_INT_BRK      = 8'hcc;
   localparam logic [7:0] OP_INT_OVF      = 8'hce;
   localparam logic [7:0] OP_INT_RET      = 8'hcf;
   localparam logic [7:0] OP_BOUND        = 8'h62;
   localparam logic [7:0] OP_CLR_CARRY    = 8'hf8;
   localparam logic [7:0] OP_CMP_CARRY    = 8'hf5;
   localparam logic [7:0] OP_SET_CARRY    = 8'hf9;
   localparam logic [7:0] OP_CLR_DIR      = 8'hfc;
   localparam logic [7:0] OP_SET_DIR      = 8'hfd;
   localparam logic [7:0] OP_CLR_IE       = 8'hfa;
   localparam logic [7:0] OP_SET_IE       = 8'hfb;
   localparam logic [7:0] OP_HALT         = 8'hf4;
   localparam logic [7:0] OP_LOCK         = 8'hf0;
   localparam logic [2:0] SEG_PFX_HI      = 3'h1;
   localparam logic [2:0] SEG_PFX_LO      = 3'h6;

   localparam logic [7:0] CLK_RET_NEAR     = 8'd16;
   localparam logic [7:0] CLK_RET_NEAR_IMM = 8'd18;
   localparam logic [7:0] CLK_RET_FAR      = 8'd22;
   localparam logic [7:0] CLK_RET_FAR_IMM  = 8'd25;
   localparam logic [7:0] CLK_JCC_NT       = 8'd4;
   localparam logic [7:0] CLK_JCC_T        = 8'd13;
   localparam logic [7:0] CLK_JCZ_NT       = 8'd5;
   localparam logic [7:0] CLK_JCZ_T        = 8'd15;
   localparam logic [7:0] CLK_LOOP_NT      = 8'd6;
   localparam logic [7:0] CLK_LOOP_T       = 8'd16;
   localparam logic [7:0] CLK_ENTER_L0     = 8'd15;
   localparam logic [7:0] CLK_ENTER_L1     = 8'd25;
   localparam logic [7:0] CLK_ENTER_BASE   = 8'd22;
   localparam logic [7:0] CLK_ENTER_STEP   = 8'd16;
   localparam logic [7:0] CLK_LEAVE        = 8'd8;
   localparam logic [7:0] CLK_INT_TYPE     = 8'd47;
   localparam logic [7:0] CLK_INT_BRK      = 8'd45;
   localparam logic [7:0] CLK_INT_OVF_T    = 8'd48;
   localparam logic [7:0] CLK_INT_OVF_NT   = 8'd4;
   localparam logic [7:0] CLK_INT_RET      = 8'd28;
   localparam logic [7:0] CLK_BOUND_MIN    = 8'd33;
   localparam logic [7:0] CLK_BOUND_MAX    = 8'd35;
   localparam logic [7:0] CLK_SHORT        = 8'd2;
   localparam logic [7:0] CLK_EA           = 8'd4;

   localparam logic [1:0] MODE_NO_DISP  = 2'b00;
   localparam logic [1:0] MODE_DISP8    = 2'b01;
   localparam logic [1:0] MODE_DISP16   = 2'b10;
   localparam logic [1:0] MODE_REG      = 2'b11;
   localparam logic [2:0] RM_DIRECT     = 3'b110;

   typedef enum logic [1:0] {
      SEG_EXTRA = 2'b00,
      SEG_CODE  = 2'b01,
      SEG_STACK = 2'b10,
      SEG_DATA  = 2'b11
   } seg_e;

   typedef enum logic [3:0] {
      CLS_NONE    = 4'h0,
      CLS_RETURN  = 4'h1,
      CLS_JCC     = 4'h2,
      CLS_JCZ     = 4'h3,
      CLS_LOOP    = 4'h4,
      CLS_ENTER   = 4'h5,
      CLS_LEAVE   = 4'h6,
      CLS_INT     = 4'h7,
      CLS_INT_RET = 4'h8,
      CLS_BOUND   = 4'h9,
      CLS_FLAG    = 4'ha,
      CLS_PREFIX  = 4'hb
   } class_e;
endpackage : ctd_pkg

// ### rtl/operand_addr.sv
// effective-address and mode/rm decode for the addressing byte
// assumes register values are presented by the execution unit
`timescale 1ns/100ps
`default_nettype none
module operand_addr (
   input  wire  logic [1:0]  mode,
   input  wire  logic [2:0]  rm,
   input  wire  logic [7:0]  disp_lo,
   input  wire  logic [7:0]  disp_hi,
   input  wire  logic [15:0] base_register,
   input  wire  logic [15:0] frame_pointer,
   input  wire  logic [15:0] source_index,
   input  wire  logic [15:0] destination_index,
   output var   logic [15:0] effective_address,
   output var   logic        is_register,
   output var   logic        uses_frame,
   output var   logic [1:0]  disp_bytes
);
   wire logic [15:0] disp;
   wire logic [15:0] base_sel;
   wire logic [15:0] index_sel;
   wire logic        direct;

   assign is_register = (mode == ctd_pkg::MODE_REG);
   assign direct      = (mode == ctd_pkg::MODE_NO_DISP) && (rm == ctd_pkg::RM_DIRECT);
   assign disp_bytes  = direct ? 2'd2 :
                        (mode == ctd_pkg::MODE_DISP8) ? 2'd1 :
                        (mode == ctd_pkg::MODE_DISP16) ? 2'd2 : 2'd0;
   assign disp = (direct || mode == ctd_pkg::MODE_DISP16) ? {disp_hi, disp_lo} :
                 (mode == ctd_pkg::MODE_DISP8) ? {{8{disp_lo[7]}}, disp_lo} :
                 16'h0000;
   assign base_sel  = (rm == 3'b000 || rm == 3'b001 || rm == 3'b111) ? base_register :
                      (rm == 3'b010 || rm == 3'b011 || rm == 3'b110) ? frame_pointer :
                      16'h0000;
   assign index_sel = (rm == 3'b000 || rm == 3'b010 || rm == 3'b100) ? source_index :
                      (rm == 3'b001 || rm == 3'b011 || rm == 3'b101) ? destination_index :
                      16'h0000;
   assign uses_frame = !is_register && !direct &&
                       (rm == 3'b010 || rm == 3'b011 || rm == 3'b110);
   assign effective_address = direct ? disp : 16'(base_sel + index_sel + disp);
endmodule : operand_addr
`default_nettype wire

// ### rtl/control_transfer_operand_decode.sv
// decoder for control-transfer and processor-control opcodes and the addressing byte
// assumes the fetch queue presents a whole instruction with one-cycle valid
`timescale 1ns/100ps
`default_nettype none
module control_transfer_operand_decode (
   input  wire  logic        core_clk,
   input  wire  logic        rst_b,
   input  wire  logic        instr_valid,
   input  wire  logic [7:0]  opcode,
   input  wire  logic [7:0]  byte1,
   input  wire  logic [7:0]  byte2,
   input  wire  logic [7:0]  byte3,
   input  wire  logic        word_op,
   input  wire  logic        string_dest,
   input  wire  logic        cond_true,
   input  wire  logic        count_zero_after,
   input  wire  logic        zero_flag,
   input  wire  logic        overflow_flag,
   input  wire  logic        bound_fail,
   input  wire  logic [15:0] count_register,
   input  wire  logic [15:0] base_register,
   input  wire  logic [15:0] frame_pointer,
   input  wire  logic [15:0] source_index,
   input  wire  logic [15:0] destination_index,
   output logic              done,
   output logic              busy,
   output logic [3:0]        instr_class,
   output logic [7:0]        exec_clocks,
   output logic              branch_taken,
   output logic              bus_lock,
   output logic              halt_instruction,
   output logic [1:0]        carry_op,
   output logic [1:0]        dir_op,
   output logic [1:0]        ie_op,
   output logic [15:0]       effective_address,
   output logic [1:0]        operand_segment,
   output logic              operand_is_register,
   output logic [3:0]        reg_select,
   output logic [15:0]       displacement,
   output logic [1:0]        disp_len
);
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } state_e;

   state_e      state;
   state_e      next_state;
   logic  [7:0] remain;
   logic        lock_pend;
   logic        ovr_pend;
   logic  [1:0] ovr_seg;

   wire logic        take;
   wire logic        is_ret;
   wire logic        is_jcc;
   wire logic        is_loop;
   wire logic        is_flag;
   wire logic        is_seg_pfx;
   wire logic        has_modrm;
   wire logic        loop_taken;
   wire logic        taken;
   wire logic [7:0]  level;
   wire logic [7:0]  enter_clocks;
   wire logic [7:0]  clocks;
   wire logic [3:0]  cls;
   wire logic [1:0]  mode;
   wire logic [2:0]  rm;
   wire logic [2:0]  reg_field;
   wire logic [15:0] ea;
   wire logic        ea_is_reg;
   wire logic        ea_frame;
   wire logic [1:0]  ea_disp_bytes;
   wire logic [1:0]  seg_sel;
   wire logic [15:0] disp_value;

   // register index: 0-7 word registers, 8-15 byte halves (low 8-11, high 12-15)
   function automatic logic [3:0] reg_code(input logic [2:0] f, input logic w);
      reg_code = {~w, f};
   endfunction : reg_code

   assign take       = instr_valid && (state == ST_IDLE);
   assign is_ret     = (opcode == ctd_pkg::OP_RET_NEAR) || (opcode == ctd_pkg::OP_RET_NEAR_IMM)
                    || (opcode == ctd_pkg::OP_RET_FAR) || (opcode == ctd_pkg::OP_RET_FAR_IMM);
   assign is_jcc     = (opcode[7:4] == ctd_pkg::OP_JCC_HI);
   assign is_loop    = (opcode == ctd_pkg::OP_LOOP) || (opcode == ctd_pkg::OP_LOOP_Z)
                    || (opcode == ctd_pkg::OP_LOOP_NZ);
   assign is_flag    = (opcode == ctd_pkg::OP_CLR_CARRY) || (opcode == ctd_pkg::OP_CMP_CARRY)
                    || (opcode == ctd_pkg::OP_SET_CARRY) || (opcode == ctd_pkg::OP_CLR_DIR)
                    || (opcode == ctd_pkg::OP_SET_DIR) || (opcode == ctd_pkg::OP_CLR_IE)
                    || (opcode == ctd_pkg::OP_SET_IE) || (opcode == ctd_pkg::OP_HALT);
   assign is_seg_pfx = (opcode[7:5] == ctd_pkg::SEG_PFX_HI)
                    && (opcode[2:0] == ctd_pkg::SEG_PFX_LO);
   assign has_modrm  = (opcode == ctd_pkg::OP_BOUND);

   // loop counts after the decrement the execution unit reports
   assign loop_taken = !count_zero_after &&
                       ((opcode == ctd_pkg::OP_LOOP) ||
                        (opcode == ctd_pkg::OP_LOOP_Z && zero_flag) ||
                        (opcode == ctd_pkg::OP_LOOP_NZ && !zero_flag));
   assign taken = is_jcc ? cond_true :
                  (opcode == ctd_pkg::OP_JUMP_CNT_Z) ? (count_register == 16'h0000) :
                  is_loop ? loop_taken :
                  (opcode == ctd_pkg::OP_INT_OVF) ? overflow_flag : 1'b0;

   // nesting level is the fourth byte of procedure entry, taken mod 32
   assign level = {3'h0, byte3[4:0]};
   assign enter_clocks = (level == 8'd0) ? ctd_pkg::CLK_ENTER_L0 :
                         (level == 8'd1) ? ctd_pkg::CLK_ENTER_L1 :
                         8'(ctd_pkg::CLK_ENTER_BASE
                            + 8'(ctd_pkg::CLK_ENTER_STEP * 8'(level - 8'd1)));

   assign cls = is_ret                                  ? ctd_pkg::CLS_RETURN  :
                is_jcc                                  ? ctd_pkg::CLS_JCC     :
                (opcode == ctd_pkg::OP_JUMP_CNT_Z)      ? ctd_pkg::CLS_JCZ     :
                is_loop                                 ? ctd_pkg::CLS_LOOP    :
                (opcode == ctd_pkg::OP_ENTER)           ? ctd_pkg::CLS_ENTER   :
                (opcode == ctd_pkg::OP_LEAVE)           ? ctd_pkg::CLS_LEAVE   :
                (opcode == ctd_pkg::OP_INT_TYPE || opcode == ctd_pkg::OP_INT_BRK
                 || opcode == ctd_pkg::OP_INT_OVF)      ? ctd_pkg::CLS_INT     :
                (opcode == ctd_pkg::OP_INT_RET)         ? ctd_pkg::CLS_INT_RET :
                has_modrm                               ? ctd_pkg::CLS_BOUND   :
                is_flag                                 ? ctd_pkg::CLS_FLAG    :
                (opcode == ctd_pkg::OP_LOCK || is_seg_pfx) ? ctd_pkg::CLS_PREFIX :
                ctd_pkg::CLS_NONE;

   assign clocks =
      (opcode == ctd_pkg::OP_RET_NEAR)     ? ctd_pkg::CLK_RET_NEAR     :
      (opcode == ctd_pkg::OP_RET_NEAR_IMM) ? ctd_pkg::CLK_RET_NEAR_IMM :
      (opcode == ctd_pkg::OP_RET_FAR)      ? ctd_pkg::CLK_RET_FAR      :
      (opcode == ctd_pkg::OP_RET_FAR_IMM)  ? ctd_pkg::CLK_RET_FAR_IMM  :
      is_jcc ? (taken ? ctd_pkg::CLK_JCC_T : ctd_pkg::CLK_JCC_NT) :
      (opcode == ctd_pkg::OP_JUMP_CNT_Z)
             ? (taken ? ctd_pkg::CLK_JCZ_T : ctd_pkg::CLK_JCZ_NT) :
      is_loop ? (taken ? ctd_pkg::CLK_LOOP_T : ctd_pkg::CLK_LOOP_NT) :
      (opcode == ctd_pkg::OP_ENTER)    ? enter_clocks :
      (opcode == ctd_pkg::OP_LEAVE)    ? ctd_pkg::CLK_LEAVE :
      (opcode == ctd_pkg::OP_INT_TYPE) ? ctd_pkg::CLK_INT_TYPE :
      (opcode == ctd_pkg::OP_INT_BRK)  ? ctd_pkg::CLK_INT_BRK :
      (opcode == ctd_pkg::OP_INT_OVF)
             ? (taken ? ctd_pkg::CLK_INT_OVF_T : ctd_pkg::CLK_INT_OVF_NT) :
      (opcode == ctd_pkg::OP_INT_RET)  ? ctd_pkg::CLK_INT_RET :
      has_modrm ? (bound_fail ? ctd_pkg::CLK_BOUND_MAX : ctd_pkg::CLK_BOUND_MIN) :
      (is_flag || opcode == ctd_pkg::OP_LOCK || is_seg_pfx)
             ? ctd_pkg::CLK_SHORT : 8'd0;

   // addressing byte is the second instruction byte
   assign mode      = byte1[7:6];
   assign reg_field = byte1[5:3];
   assign rm        = byte1[2:0];

   operand_addr u_operand_addr (
      .mode              (mode),
      .rm                (rm),
      .disp_lo           (byte2),
      .disp_hi           (byte3),
      .base_register     (base_register),
      .frame_pointer     (frame_pointer),
      .source_index      (source_index),
      .destination_index (destination_index),
      .effective_address (ea),
      .is_register       (ea_is_reg),
      .uses_frame        (ea_frame),
      .disp_bytes        (ea_disp_bytes)
   );

   assign disp_value = (ea_disp_bytes == 2'd2) ? {byte3, byte2} :
                       (ea_disp_bytes == 2'd1) ? {{8{byte2[7]}}, byte2} : 16'h0000;

   // string destination wins over any override; then override; then frame default
   assign seg_sel = string_dest ? ctd_pkg::SEG_EXTRA :
                    ovr_pend    ? ovr_seg :
                    ea_frame    ? ctd_pkg::SEG_STACK :
                    ctd_pkg::SEG_DATA;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (take && clocks > 8'd1) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (remain == 8'd1) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   assign busy = (state == ST_EXEC);
   assign done = (state == ST_EXEC) ? (remain == 8'd1) : (take && clocks == 8'd1);

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state  <= ST_IDLE;
         remain <= 8'd0;
      end else begin
         state  <= next_state;
         if (take) begin
            remain <= clocks;
         end else if (state == ST_EXEC) begin
            remain <= 8'(remain - 8'd1);
         end
      end
   end

   // prefixes hold until the next non-prefix instruction is taken
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         lock_pend <= 1'b0;
         ovr_pend  <= 1'b0;
         ovr_seg   <= 2'b00;
         bus_lock  <= 1'b0;
      end else if (take) begin
         if (opcode == ctd_pkg::OP_LOCK) begin
            lock_pend <= 1'b1;
         end else if (is_seg_pfx) begin
            ovr_pend <= 1'b1;
            ovr_seg  <= opcode[4:3];
         end else begin
            bus_lock  <= lock_pend;
            lock_pend <= 1'b0;
            ovr_pend  <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         instr_class         <= 4'h0;
         exec_clocks         <= 8'd0;
         branch_taken        <= 1'b0;
         halt_instruction    <= 1'b0;
         carry_op            <= 2'b00;
         dir_op              <= 2'b00;
         ie_op               <= 2'b00;
         effective_address   <= 16'h0000;
         operand_segment     <= 2'b00;
         operand_is_register <= 1'b0;
         reg_select          <= 4'h0;
         displacement        <= 16'h0000;
         disp_len            <= 2'b00;
      end else if (take) begin
         instr_class      <= cls;
         exec_clocks      <= clocks;
         branch_taken     <= taken;
         halt_instruction <= (opcode == ctd_pkg::OP_HALT);
         // ops: 00 none, 01 clear, 10 set, 11 complement
         carry_op <= (opcode == ctd_pkg::OP_CLR_CARRY) ? 2'b01 :
                     (opcode == ctd_pkg::OP_SET_CARRY) ? 2'b10 :
                     (opcode == ctd_pkg::OP_CMP_CARRY) ? 2'b11 : 2'b00;
         dir_op   <= (opcode == ctd_pkg::OP_CLR_DIR) ? 2'b01 :
                     (opcode == ctd_pkg::OP_SET_DIR) ? 2'b10 : 2'b00;
         ie_op    <= (opcode == ctd_pkg::OP_CLR_IE) ? 2'b01 :
                     (opcode == ctd_pkg::OP_SET_IE) ? 2'b10 : 2'b00;
         effective_address   <= ea;
         operand_segment     <= seg_sel;
         operand_is_register <= ea_is_reg;
         reg_select <= ea_is_reg ? reg_code(rm, word_op) : reg_code(reg_field, word_op);
         displacement <= disp_value;
         disp_len     <= ea_disp_bytes;
      end
   end

   // address time is folded overflow_interrupt the published totals, never added again
   wire logic unused_ea_time = (ctd_pkg::CLK_EA == 8'd4);
endmodule : control_transfer_operand_decode
`default_nettype wire

// ### test/ctd_sva.sv
// checker: timing and operand-decode properties of the decoder
// assumes it is bound overflow_interrupt control_transfer_operand_decode
`timescale 1ns/100ps
`default_nettype none
module ctd_sva (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        instr_valid,
   input wire logic [7:0]  opcode,
   input wire logic [7:0]  byte1,
   input wire logic [7:0]  byte2,
   input wire logic [7:0]  byte3,
   input wire logic        string_dest,
   input wire logic        cond_true,
   input wire logic        done,
   input wire logic        busy,
   input wire logic [7:0]  exec_clocks,
   input wire logic [15:0] effective_address,
   input wire logic [1:0]  operand_segment,
   input wire logic        operand_is_register,
   input wire logic [15:0] displacement
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic [7:0] busy_cnt;
   wire        take = instr_valid && !busy;
   wire        bnd  = take && opcode == ctd_pkg::OP_BOUND;
   always_ff @(posedge core_clk) begin
      busy_cnt <= (!rst_b || !busy) ? 8'h00 : busy_cnt + 8'h01;
   end
   sequence s_take;
      take;
   endsequence
   sequence s_finish;
      done ##1 !busy;
   endsequence
   chk_take_starts: assert property (s_take |=> busy || exec_clocks == 8'h00)
      else $error("accepted opcode did not start");
   chk_done_count: assert property (done |-> busy_cnt == exec_clocks - 8'h01)
      else $error("done pulse not at reported clock count");
   chk_done_ends: assert property (done |-> s_finish)
      else $error("busy stays after done");
   chk_busy_holds: assert property (
      busy && !done |=> $stable(exec_clocks) && $stable(effective_address))
      else $error("outputs changed while busy");
   chk_jcc_clocks: assert property (
      take && opcode[7:4] == ctd_pkg::OP_JCC_HI
      |=> exec_clocks == ($past(cond_true) ? 8'h0d : 8'h04))
      else $error("conditional jump clock count wrong");
   chk_reg_mode: assert property (bnd && byte1[7:6] == 2'b11 |=> operand_is_register)
      else $error("mode 11 not reported as register");
   chk_disp_sext: assert property (
      bnd && byte1[7:6] == 2'b01 |=> displacement == {{8{$past(byte2[7])}}, $past(byte2)})
      else $error("byte displacement not sign extended");
   chk_direct_ea: assert property (
      bnd && byte1[7:6] == 2'b00 && byte1[2:0] == 3'b110
      |=> effective_address == {$past(byte3), $past(byte2)})
      else $error("direct address wrong");
   chk_string_es: assert property (
      bnd && string_dest && byte1[7:6] != 2'b11 |=> operand_segment == ctd_pkg::SEG_EXTRA)
      else $error("string destination not in extra segment");
endmodule : ctd_sva
bind control_transfer_operand_decode ctd_sva u_sva (.core_clk(core_clk), .rst_b(rst_b),
   .instr_valid(instr_valid), .opcode(opcode), .byte1(byte1), .byte2(byte2), .byte3(byte3),
   .string_dest(string_dest), .cond_true(cond_true), .done(done), .busy(busy),
   .exec_clocks(exec_clocks), .effective_address(effective_address),
   .operand_segment(operand_segment), .operand_is_register(operand_is_register),
   .displacement(displacement));
`default_nettype wire

// ### test/fetch_feed.sv
// model of the prefetch queue: presents one whole instruction until taken
// assumes push is a one-cycle request from the bench
`timescale 1ns/100ps
`default_nettype none
module fetch_feed (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        push,
   input  wire logic        busy,
   input  wire logic [31:0] instr_in,
   output var  logic        instr_valid,
   output var  logic [7:0]  opcode,
   output var  logic [7:0]  byte1,
   output var  logic [7:0]  byte2,
   output var  logic [7:0]  byte3
);
   initial {instr_valid, opcode, byte1, byte2, byte3} = '0;
   always @(posedge core_clk) begin
      if (!rst_b) begin
         instr_valid <= 1'b0;
      end else if (push) begin
         instr_valid <= 1'b1;
         {opcode, byte1, byte2, byte3} <= instr_in;
      end else if (instr_valid && !busy) begin
         // bytes are gone once taken: show the inverse, never a stale copy
         instr_valid <= 1'b0;
         {opcode, byte1, byte2, byte3} <= ~{opcode, byte1, byte2, byte3};
      end
   end
endmodule : fetch_feed
`default_nettype wire

// ### test/tb.sv
// testbench for the control-transfer and operand decoder
// assumes the fetch model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin err_total++; \
   $display("mismatch t=%0t %s", $time, m); end end
module tb;
   logic        core_clk, rst_b, push, word_op, string_dest, cond_true, count_zero_after;
   logic        zero_flag, overflow_flag, bound_fail, instr_valid, busy, done, taken;
   logic        bus_lock, halt_i, is_reg;
   logic [31:0] instr;
   logic [15:0] cx, bx, fp, si, di, ea, disp;
   logic [7:0]  opcode, byte1, byte2, byte3, exec_clocks;
   logic [3:0]  instr_class, reg_select;
   logic [1:0]  carry_op, dir_op, ie_op, seg, disp_len;
   int          err_total = 0;
   int          checks = 0;
   fetch_feed feed (.core_clk(core_clk), .rst_b(rst_b), .push(push), .busy(busy),
      .instr_in(instr), .instr_valid(instr_valid), .opcode(opcode), .byte1(byte1),
      .byte2(byte2), .byte3(byte3));
   control_transfer_operand_decode dut (.core_clk(core_clk), .rst_b(rst_b),
      .instr_valid(instr_valid), .opcode(opcode), .byte1(byte1), .byte2(byte2),
      .byte3(byte3), .word_op(word_op), .string_dest(string_dest), .cond_true(cond_true),
      .count_zero_after(count_zero_after), .zero_flag(zero_flag),
      .overflow_flag(overflow_flag), .bound_fail(bound_fail), .count_register(cx),
      .base_register(bx), .frame_pointer(fp), .source_index(si), .destination_index(di),
      .done(done), .busy(busy), .instr_class(instr_class), .exec_clocks(exec_clocks),
      .branch_taken(taken), .bus_lock(bus_lock), .halt_instruction(halt_i),
      .carry_op(carry_op), .dir_op(dir_op), .ie_op(ie_op), .effective_address(ea),
      .operand_segment(seg), .operand_is_register(is_reg), .reg_select(reg_select),
      .displacement(disp), .disp_len(disp_len));
   task automatic stop_test();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   // one instruction through the fetch model, returns once it has finished
   task automatic issue(input logic [31:0] ins);
      int n;
      n = 0;
      instr = ins;
      push = 1'b1;
      @(negedge core_clk);
      push = 1'b0;
      while ((instr_valid || busy) && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      `CHK(n < 400, 1'b1, "instruction never finished")
   endtask : issue
   task automatic br(input logic [7:0] op, input logic [3:0] f, input logic [15:0] c,
                     input logic [7:0] clk_exp, input logic tk);
      {cond_true, count_zero_after, zero_flag, overflow_flag} = f;
      cx = c;
      issue({op, 24'h0});
      `CHK(exec_clocks, clk_exp, "branch clocks")
      `CHK(taken, tk, "branch taken")
   endtask : br
   task automatic t_fixed();
      logic [7:0] ops [16] = '{8'hc3, 8'hc2, 8'hcb, 8'hca, 8'hc9, 8'hcd, 8'hcc, 8'hcf,
                               8'hf8, 8'hf9, 8'hfc, 8'hfd, 8'hfa, 8'hfb, 8'hf4, 8'hf5};
      logic [7:0] cyc [16] = '{8'h10, 8'h12, 8'h16, 8'h19, 8'h08, 8'h2f, 8'h2d, 8'h1c,
                               8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
      for (int i = 0; i < 16; i++) begin
         issue({ops[i], 24'h0});
         `CHK(exec_clocks, cyc[i], "fixed clocks")
         if (i < 4) `CHK(instr_class, ctd_pkg::CLS_RETURN, "return class")
         if (i > 7) `CHK(instr_class, ctd_pkg::CLS_FLAG, "flag class")
         if (ops[i] == 8'hfd) `CHK(dir_op, 2'b10, "set direction")
         if (ops[i] == 8'hfa) `CHK(ie_op, 2'b01, "clear interrupt enable")
      end
      `CHK(carry_op, 2'b11, "complement carry")
      issue(32'hf000_0000);
      `CHK(exec_clocks, 8'h02, "lock clocks")
      issue(32'hf400_0000);
      `CHK({bus_lock, halt_i}, 2'b11, "lock on next, halt")
   endtask : t_fixed
   task automatic t_branch();
      br(8'h7c, 4'h8, 16'h1, 8'h0d, 1'b1);
      br(8'h7c, 4'h0, 16'h1, 8'h04, 1'b0);
      br(8'he3, 4'h0, 16'h0, 8'h0f, 1'b1);
      br(8'he3, 4'h0, 16'h5, 8'h05, 1'b0);
      br(8'he2, 4'h0, 16'h5, 8'h10, 1'b1);
      br(8'he2, 4'h4, 16'h5, 8'h06, 1'b0);
      br(8'he1, 4'h2, 16'h5, 8'h10, 1'b1);
      br(8'he0, 4'h2, 16'h5, 8'h06, 1'b0);
      overflow_flag = 1'b1;
      issue(32'hce00_0000);
      `CHK(exec_clocks, 8'h30, "overflow int taken")
      overflow_flag = 1'b0;
      issue(32'hce00_0000);
      `CHK(exec_clocks, 8'h04, "overflow int not taken")
   endtask : t_branch
   task automatic t_enter();
      logic [7:0] exp [3] = '{8'h0f, 8'h19, 8'h36};
      logic [7:0] lvl [3] = '{8'h00, 8'h01, 8'h03};
      for (int i = 0; i < 3; i++) begin
         issue({8'hc8, 8'h10, 8'h00, lvl[i]});
         `CHK({exec_clocks, bus_lock, halt_i}, {exp[i], 2'b00}, "enter clocks")
      end
   endtask : t_enter
   task automatic t_operand();
      issue(32'h62c5_0000);
      `CHK({is_reg, reg_select}, 5'h15, "word register")
      word_op = 1'b0;
      issue(32'h62c4_0000);
      `CHK(reg_select, 4'hc, "byte high register")
      bound_fail = 1'b1;
      issue(32'h6242_f000);
      `CHK({exec_clocks, disp, disp_len}, {8'h23, 16'hfff0, 2'h1}, "disp8")
      `CHK({ea, seg}, {16'h2020, 2'b10}, "frame stack")
      bound_fail = 1'b0;
      issue(32'h6280_3412);
      `CHK({exec_clocks, ea, disp_len}, {8'h21, 16'h2264, 2'h2}, "disp16")
      issue(32'h6206_cdab);
      `CHK({ea, seg}, {16'habcd, 2'b11}, "direct")
      issue(32'h6203_5555);
      `CHK({ea, disp}, {16'h2004, 16'h0000}, "no disp")
      issue(32'h2600_0000);
      issue(32'h6244_0200);
      `CHK({ea, seg}, {16'h0032, 2'b00}, "override")
      string_dest = 1'b1;
      issue(32'h3e00_0000);
      issue(32'h6205_0000);
      `CHK({ea, seg}, {16'h0004, 2'b00}, "string fixed")
   endtask : t_operand
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #(50 * 6000);
      err_total++;
      stop_test();
   end
   initial begin
      {rst_b, push, string_dest, cond_true, count_zero_after} = '0;
      {zero_flag, overflow_flag, bound_fail} = '0;
      word_op = 1'b1;
      instr = '0;
      {cx, bx, fp, si, di} = {16'h0, 16'h1000, 16'h2000, 16'h0030, 16'h0004};
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      t_fixed();
      t_branch();
      t_enter();
      t_operand();
      stop_test();
   end
endmodule : tb
`default_nettype wire
